/* inc/timer8_map.svh */
// register map, field positions, reset values and prescaler taps of the 8-bit timer
// assumes a 32-bit AHB-Lite slave with one aligned word per register
`ifndef TIMER8_MAP_SVH
`define TIMER8_MAP_SVH
// word offsets (byte addresses)
`define T8_OFS_CONTROL 5'h00
`define T8_OFS_COUNT 5'h04
`define T8_OFS_COMPARE 5'h08
`define T8_OFS_IRQ_MASK 5'h0C
`define T8_OFS_FLAGS 5'h10
`define T8_OFS_AUX 5'h14
// control register fields
`define T8_FORCE_BIT 7
`define T8_MODE_HIGH_BIT 6
`define T8_MODE_LOW_BIT 3
`define T8_COM_HIGH_BIT 5
`define T8_COM_LOW_BIT 4
`define T8_CS_HIGH_BIT 2
// mask, flag and auxiliary fields
`define T8_COMPARE_BIT 1
`define T8_OVERFLOW_BIT 0
`define T8_AUX_GIE_BIT 0
`define T8_AUX_DDR_BIT 1
// counter limits and reset values
`define T8_MAX 8'hFF
`define T8_BOTTOM 8'h00
`define T8_ZERO8 8'h00
// prescaler tap masks: tick when the masked bits are all ones
`define T8_DIV8_MASK 10'h007
`define T8_DIV64_MASK 10'h03F
`define T8_DIV256_MASK 10'h0FF
`define T8_DIV1024_MASK 10'h3FF
`define T8_PRESCALE_MIN_W 10
`endif

/* inc/timer8_pkg.sv */
// types of the 8-bit compare/PWM timer
// assumes the map header supplies the offsets, field positions and limits used by the logic
package timer8_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00, MODE_PHASE_PWM = 2'b01, MODE_CLEAR_ON_MATCH = 2'b10,
    MODE_FAST_PWM = 2'b11
  } wave_mode_t;
  typedef enum logic [1:0] {
    COM_OFF = 2'b00, COM_TOGGLE = 2'b01, COM_CLEAR = 2'b10, COM_SET = 2'b11
  } com_mode_t;
  typedef enum logic [2:0] {
    CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010, CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101, CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
  } clk_sel_t;
  typedef struct packed {
    logic [9:0] prescale;
    logic ext_prev;
    wave_mode_t mode;
    com_mode_t com;
    clk_sel_t sel;
    logic [7:0] cnt;
    logic [7:0] ocr_buf;
    logic [7:0] ocr_act;
    logic dir_down;
    logic block;
    logic wave;
    logic [1:0] mask;
    logic cflag;
    logic oflag;
    logic gie;
    logic ddr;
    logic wr_pend;
    logic [4:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic pin;
    logic pin_oe;
    logic override;
    logic cirq;
    logic oirq;
  } state_t;
endpackage

/* logic/timer8_compare_pwm_regs.sv */
// 8-bit timer/counter with one compare unit, four waveform modes and AHB-Lite registers
// assumes inputs synchronous to sys_clk_i and a single AHB-Lite master
//
// How it works
// R1: synchronous logic, timer clock is count enable
// R2: force strobe acts only in non-PWM modes
// R3: software writes force zero in PWM modes
// R4: force applies compare action using written mode
// R5: force sets no flag, never clears counter
// R6: force strobe always reads as zero
// R7: mode decode; TOP is MAX or compare
// R8: compare update timing and overflow point per mode
// R9: compare mode overrides pin; driver needs direction
// R10: non-PWM match: off, toggle, clear, set
// R11: fast PWM clear/set on match, BOTTOM
// R12: fast PWM compare at TOP ignored
// R13: phase PWM up/down match actions opposite
// R14: phase PWM compare at TOP acts at TOP
// R15: clock select: stop, 1, 8, 64, 256, 1024
// R16: external pin falling or rising edge counts
// R17: external pin counts even when output
// R18: counter read/write; write blocks next match
// R19: compare register continuously compared to counter
// R20: compare request needs enable, global, flag
// R21: overflow request needs enable, global, flag
// R22: compare flag set on match, cleared by ack/W1C
// R23: control, counter, compare reset to zero
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`include "timer8_map.svh"

module timer8_compare_pwm_regs #(
  parameter int PRESCALE_W = 10
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  // external count pin
  input wire logic external_count_pin_i,
  // waveform output pin
  output logic waveform_output_o,
  output logic waveform_output_oe_o,
  output logic pin_override_o,
  // interrupt requests and vector acknowledges
  input wire logic compare_irq_ack_i,
  input wire logic overflow_irq_ack_i,
  output logic compare_irq_o,
  output logic overflow_irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration check

  // the prescaler width must be exactly the 10 bits of the 1024 divider tap mask
  if (PRESCALE_W != `T8_PRESCALE_MIN_W)
  begin : g_bad_width
    $error("prescaler width must equal the widest divider width");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state

  timer8_pkg::state_t state_reg;
  timer8_pkg::state_t state_next;
  logic addr_phase;
  logic tce;
  logic wr_ctrl;
  logic wr_cnt;
  logic force_hit;
  logic match;
  logic at_max;
  logic top_ev;
  logic [7:0] rd;
  logic com_hi;
  logic pwm_mode;
  logic ovf_set;

  // address phase taken only when selected, with htrans NONSEQ or SEQ and the bus ready; hsize is ignored (word only)
  assign addr_phase = hsel_i && htrans_i[1] && hready_i;

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    state_next = state_reg;
    // free running prescaler, shared by all divided taps
    state_next.prescale = state_reg.prescale + 10'h001;
    state_next.ext_prev = external_count_pin_i;
    // timer clock as a one-cycle enable; pin edges count regardless of direction
    case (state_reg.sel) // R1 R15 R16 R17
      timer8_pkg::CS_STOP: tce = 1'b0;
      timer8_pkg::CS_DIV1: tce = 1'b1;
      timer8_pkg::CS_DIV8: tce = (state_reg.prescale & `T8_DIV8_MASK) == `T8_DIV8_MASK;
      timer8_pkg::CS_DIV64: tce = (state_reg.prescale & `T8_DIV64_MASK) == `T8_DIV64_MASK;
      timer8_pkg::CS_DIV256: tce = (state_reg.prescale & `T8_DIV256_MASK) == `T8_DIV256_MASK;
      timer8_pkg::CS_DIV1024:
        tce = (state_reg.prescale & `T8_DIV1024_MASK) == `T8_DIV1024_MASK;
      timer8_pkg::CS_EXT_FALL: tce = state_reg.ext_prev && !external_count_pin_i;
      timer8_pkg::CS_EXT_RISE: tce = !state_reg.ext_prev && external_count_pin_i;
      default: tce = 1'b0;
    endcase
    pwm_mode = state_reg.mode == timer8_pkg::MODE_PHASE_PWM
      || state_reg.mode == timer8_pkg::MODE_FAST_PWM;
    com_hi = state_reg.com[1];
    at_max = state_reg.cnt == `T8_MAX;
    // continuous compare, suppressed once after a counter write
    match = tce && !state_reg.block && state_reg.cnt == state_reg.ocr_act; // R19 R18
    top_ev = tce && at_max;
    wr_ctrl = state_reg.wr_pend && state_reg.wr_addr == `T8_OFS_CONTROL;
    wr_cnt = state_reg.wr_pend && state_reg.wr_addr == `T8_OFS_COUNT;
    force_hit = 1'b0;
    // overflow point: BOTTOM turn in phase correct, MAX step in the other modes
    ovf_set = tce && ((state_reg.mode == timer8_pkg::MODE_PHASE_PWM)
      ? (state_reg.dir_down && state_reg.cnt == `T8_BOTTOM) : at_max); // R8

    // counter sequence per waveform mode
    if (tce)
    begin
      state_next.block = 1'b0;
      case (state_reg.mode)
        timer8_pkg::MODE_CLEAR_ON_MATCH:
        begin
          // TOP is the compare value here
          state_next.cnt = (state_reg.cnt == state_reg.ocr_act) ? `T8_BOTTOM
            : state_reg.cnt + 8'h01; // R7
          if (at_max)
            state_next.oflag = 1'b1; // R8
        end
        timer8_pkg::MODE_PHASE_PWM:
        begin
          // each end value is held for exactly one timer clock
          if (state_reg.dir_down && state_reg.cnt == `T8_BOTTOM)
          begin
            state_next.dir_down = 1'b0;
            state_next.cnt = state_reg.cnt + 8'h01;
            state_next.oflag = 1'b1; // R8
          end
          else if (!state_reg.dir_down && at_max)
          begin
            state_next.dir_down = 1'b1;
            state_next.cnt = state_reg.cnt - 8'h01;
          end
          else if (state_reg.dir_down)
            state_next.cnt = state_reg.cnt - 8'h01;
          else
            state_next.cnt = state_reg.cnt + 8'h01;
        end
        default:
        begin
          // normal and fast PWM wrap from MAX to BOTTOM
          state_next.cnt = state_reg.cnt + 8'h01; // R7
          if (at_max)
            state_next.oflag = 1'b1; // R8
        end
      endcase
      if (match)
        state_next.cflag = 1'b1; // R22
    end

    // compare buffer transfer point per mode
    case (state_reg.mode) // R8
      timer8_pkg::MODE_PHASE_PWM:
        if (top_ev)
          state_next.ocr_act = state_reg.ocr_buf;
      timer8_pkg::MODE_FAST_PWM:
        if (top_ev)
          state_next.ocr_act = state_reg.ocr_buf;
      default: state_next.ocr_act = state_reg.ocr_buf;
    endcase

    // waveform generator
    case (state_reg.mode)
      timer8_pkg::MODE_FAST_PWM:
      begin
        // compare at TOP with high bit set gives a steady level
        if (match && com_hi && state_reg.ocr_act != `T8_MAX) // R11 R12
          state_next.wave = state_reg.com[0];
        if (top_ev && com_hi) // R11 R12
          state_next.wave = !state_reg.com[0];
      end
      timer8_pkg::MODE_PHASE_PWM:
      begin
        if (com_hi && state_reg.ocr_act == `T8_MAX)
        begin
          if (top_ev) // R14
            state_next.wave = !state_reg.com[0];
        end
        else if (match && com_hi) // R13
          state_next.wave = state_reg.dir_down ? !state_reg.com[0] : state_reg.com[0];
      end
      default:
        if (match)
        begin
          case (state_reg.com) // R10
            timer8_pkg::COM_TOGGLE: state_next.wave = !state_reg.wave;
            timer8_pkg::COM_CLEAR: state_next.wave = 1'b0;
            timer8_pkg::COM_SET: state_next.wave = 1'b1;
            default: state_next.wave = state_reg.wave;
          endcase
        end
    endcase

    // data phase of a write; written values win over counting
    if (wr_ctrl)
    begin
      state_next.mode = timer8_pkg::wave_mode_t'({hwdata_i[`T8_MODE_HIGH_BIT],
        hwdata_i[`T8_MODE_LOW_BIT]}); // R7
      state_next.com = timer8_pkg::com_mode_t'(hwdata_i[`T8_COM_HIGH_BIT:`T8_COM_LOW_BIT]);
      state_next.sel = timer8_pkg::clk_sel_t'(hwdata_i[`T8_CS_HIGH_BIT:0]); // R15
      // force is a strobe: it touches only the output, not flag or counter
      force_hit = hwdata_i[`T8_FORCE_BIT] && !hwdata_i[`T8_MODE_LOW_BIT]; // R2 R5
      if (force_hit)
      begin
        case (hwdata_i[`T8_COM_HIGH_BIT:`T8_COM_LOW_BIT]) // R4
          2'b01: state_next.wave = !state_reg.wave;
          2'b10: state_next.wave = 1'b0;
          2'b11: state_next.wave = 1'b1;
          default: state_next.wave = state_reg.wave;
        endcase
      end
    end
    if (wr_cnt)
    begin
      state_next.cnt = hwdata_i[7:0]; // R18
      state_next.block = 1'b1; // R18
    end
    if (state_reg.wr_pend && state_reg.wr_addr == `T8_OFS_COMPARE)
      state_next.ocr_buf = hwdata_i[7:0];
    if (state_reg.wr_pend && state_reg.wr_addr == `T8_OFS_IRQ_MASK)
      state_next.mask = hwdata_i[`T8_COMPARE_BIT:`T8_OVERFLOW_BIT];
    if (state_reg.wr_pend && state_reg.wr_addr == `T8_OFS_AUX)
    begin
      state_next.gie = hwdata_i[`T8_AUX_GIE_BIT];
      state_next.ddr = hwdata_i[`T8_AUX_DDR_BIT];
    end

    // flag clear by one-write or vector ack; a same-cycle set wins
    if ((state_reg.wr_pend && state_reg.wr_addr == `T8_OFS_FLAGS
        && hwdata_i[`T8_COMPARE_BIT]) || compare_irq_ack_i)
      state_next.cflag = match; // R22
    if ((state_reg.wr_pend && state_reg.wr_addr == `T8_OFS_FLAGS
        && hwdata_i[`T8_OVERFLOW_BIT]) || overflow_irq_ack_i)
      state_next.oflag = ovf_set; // R8

    // register read mux, evaluated in the address phase
    case (haddr_i[4:0])
      `T8_OFS_CONTROL: rd = {1'b0, state_reg.mode[1], state_reg.com, state_reg.mode[0],
        state_reg.sel}; // R6
      `T8_OFS_COUNT: rd = state_reg.cnt;
      `T8_OFS_COMPARE: rd = state_reg.ocr_buf;
      `T8_OFS_IRQ_MASK: rd = {6'h00, state_reg.mask};
      `T8_OFS_FLAGS: rd = {6'h00, state_reg.cflag, state_reg.oflag};
      `T8_OFS_AUX: rd = {6'h00, state_reg.ddr, state_reg.gie};
      default: rd = `T8_ZERO8;
    endcase

    // bus slave: zero wait states, always OKAY, unmapped reads zero
    state_next.hreadyout = 1'b1;
    state_next.wr_pend = addr_phase && hwrite_i;
    state_next.wr_addr = haddr_i[4:0];
    state_next.hrdata = (addr_phase && !hwrite_i) ? {24'h000000, rd} : 32'h00000000;

    // pin and request outputs registered from the settled state
    state_next.override = state_reg.com != timer8_pkg::COM_OFF; // R9
    state_next.pin_oe = state_reg.com != timer8_pkg::COM_OFF && state_reg.ddr; // R9
    state_next.pin = state_reg.wave;
    state_next.cirq = state_reg.cflag && state_reg.mask[`T8_COMPARE_BIT] && state_reg.gie; // R20
    state_next.oirq = state_reg.oflag && state_reg.mask[`T8_OVERFLOW_BIT] && state_reg.gie; // R21
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  // everything but hreadyout resets to zero: timer stopped, output disconnected
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0; // R23
      state_reg.hreadyout <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  assign hreadyout_o = state_reg.hreadyout;
  assign hrdata_o = state_reg.hrdata;
  assign hresp_o = 1'b0;
  assign waveform_output_o = state_reg.pin;
  assign waveform_output_oe_o = state_reg.pin_oe;
  assign pin_override_o = state_reg.override;
  assign compare_irq_o = state_reg.cirq;
  assign overflow_irq_o = state_reg.oirq;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  // force read back as zero in the data phase of a control read
  property p_force_reads_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    (addr_phase && !hwrite_i && haddr_i[4:0] == `T8_OFS_CONTROL) |=> !hrdata_o[7];
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("force read one"); // R6

  // a stopped timer holds its count unless software writes it
  property p_stopped;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg.sel == timer8_pkg::CS_STOP && !wr_cnt) |=> $stable(state_reg.cnt);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer counted"); // R15

  // undivided clock in normal mode counts every cycle
  property p_div1_counts;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg.sel == timer8_pkg::CS_DIV1 && state_reg.mode == timer8_pkg::MODE_NORMAL
      && !wr_cnt) |=> state_reg.cnt == $past(state_reg.cnt) + 8'h01;
  endproperty
  a_div1_counts: assert property (p_div1_counts) else $error("undivided count missed"); // R15

  // clear-on-match returns to BOTTOM after the compare value
  property p_ctc_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg.mode == timer8_pkg::MODE_CLEAR_ON_MATCH && tce && !wr_cnt
      && state_reg.cnt == state_reg.ocr_act) |=> state_reg.cnt == `T8_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("counter not cleared at TOP"); // R7

  // overflow flag follows a MAX step in normal mode
  property p_ovf_max;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg.mode == timer8_pkg::MODE_NORMAL && tce && at_max && !overflow_irq_ack_i)
      |=> state_reg.oflag;
  endproperty
  a_ovf_max: assert property (p_ovf_max) else $error("overflow flag not set at MAX"); // R8

  // direction and a compare mode give driver enable and override, one cycle after both conditions
  property p_oe_needs_ddr;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg.ddr && state_reg.com != timer8_pkg::COM_OFF) ##1 $stable(state_reg.com)
      && state_reg.ddr |=> waveform_output_oe_o && pin_override_o;
  endproperty
  a_oe_needs_ddr: assert property (p_oe_needs_ddr) else $error("pin driver not enabled"); // R9

  // toggle mode flips the output on a match
  property p_toggle;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg.mode == timer8_pkg::MODE_NORMAL && state_reg.com == timer8_pkg::COM_TOGGLE
      && match && !wr_ctrl) |=> state_reg.wave != $past(state_reg.wave);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle on match missing"); // R10

  // phase correct turns down after MAX
  property p_phase_turn;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg.mode == timer8_pkg::MODE_PHASE_PWM && top_ev && !state_reg.dir_down
      && !wr_cnt) |=> state_reg.dir_down && state_reg.cnt == 8'hFE;
  endproperty
  a_phase_turn: assert property (p_phase_turn) else $error("no turn at MAX"); // R13

  // compare request tracks its three terms with one cycle of latency
  property p_cmp_irq;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_reg.cflag && state_reg.mask[`T8_COMPARE_BIT] && state_reg.gie) |=> compare_irq_o;
  endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("compare request missing"); // R20

  // a counter write blocks the match on the next timer clock
  property p_write_blocks;
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_cnt |=> !match;
  endproperty
  a_write_blocks: assert property (p_write_blocks) else $error("match after count write"); // R18

  // reserved compare mode in either PWM mode leaves the output alone
  property p_pwm_reserved;
    @(posedge sys_clk_i) disable iff (rst_i)
    (pwm_mode && state_reg.com == timer8_pkg::COM_TOGGLE && !wr_ctrl)
      |=> $stable(state_reg.wave);
  endproperty
  a_pwm_reserved: assert property (p_pwm_reserved) else $error("reserved mode acted"); // R11

endmodule // timer8_compare_pwm_regs

/* bench/timer8_pin_model.sv */
// far side of the timer pins: a source on the external count pin and the pad of the waveform pin
// assumes the bench raises go_i for one cycle with a pulse count; the pad has a pull-up
module timer8_pin_model #(
  parameter int HALF = 3
) (
  // clock
  input wire logic clk_i,
  // commands from the bench
  input wire logic go_i,
  input wire logic [7:0] pulses_i,
  // waveform pin as driven by the timer
  input wire logic wave_i,
  input wire logic wave_oe_i,
  // pins seen by the timer and the bench
  output logic count_pin_o,
  output logic pad_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] edges_left;
  int unsigned hold;
  initial
  begin
    count_pin_o = 1'b0;
    edges_left = '0;
    hold = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // each level stands HALF+1 cycles, longer than one sample period, so no edge is lost
  always @(posedge clk_i)
  begin
    if (go_i)
    begin
      edges_left <= {pulses_i, 1'b0};
      hold <= HALF;
    end
    else if (hold != 0)
      hold <= hold - 1;
    else if (edges_left != 0)
    begin
      count_pin_o <= ~count_pin_o;
      edges_left <= edges_left - 9'h001;
      hold <= HALF;
    end
  end
  // pad floats up when the driver is off
  assign busy_o = go_i | (edges_left != 0);
  assign pad_o = wave_oe_i ? wave_i : 1'b1;
endmodule // timer8_pin_model

/* bench/test_timer8_compare_pwm_regs.sv */
// self-checking bench of the 8-bit compare/PWM timer, registers reached over AHB-Lite
// assumes the map header offsets and a slave whose hreadyout is the bus hready
`include "timer8_map.svh"
`define CHK(got, exp) \
  begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_timer8_compare_pwm_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i, rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, go, busy, pad, w0;
  logic [1:0] htrans_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd_q;
  logic external_count_pin_i, waveform_output_o, waveform_output_oe_o, pin_override_o;
  logic compare_irq_ack_i, overflow_irq_ack_i, compare_irq_o, overflow_irq_o;
  logic [7:0] pulses, c;
  int bad_count = 0;
  int n_checks = 0;
  logic [7:0] frc_ctl [4] = '{8'h90, 8'hA0, 8'hB0, 8'h90};
  logic frc_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int div_n [4] = '{8, 64, 256, 1024};
  timer8_compare_pwm_regs #(.PRESCALE_W(10)) timer8_compare_pwm_regs_inst (
    .sys_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'b010),
    .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hrdata_o, .hresp_o,
    .external_count_pin_i, .waveform_output_o, .waveform_output_oe_o, .pin_override_o,
    .compare_irq_ack_i, .overflow_irq_ack_i, .compare_irq_o, .overflow_irq_o);
  timer8_pin_model timer8_pin_model_inst (.clk_i(sys_clk_i), .go_i(go), .pulses_i(pulses),
    .wave_i(waveform_output_o), .wave_oe_i(waveform_output_oe_o),
    .count_pin_o(external_count_pin_i), .pad_o(pad), .busy_o(busy));
  ////////////////////////////////////////////////////////////////////////////////
  // clock; read data captured at the edge so the task never races the slave
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) rd_q <= hrdata_o;
  ////////////////////////////////////////////////////////////////////////////////
  // one single-word transfer: address phase held until hready, then data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] d);
    @(posedge sys_clk_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    @(negedge sys_clk_i);
    d = rd_q;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    logic [31:0] d;
    xfer(1'b1, a, {24'h000000, v}, d);
  endtask
  task automatic rd(input logic [31:0] a, output logic [7:0] v);
    logic [31:0] d;
    xfer(1'b0, a, 32'h00000000, d);
    `CHK(d[31:8], 24'h000000)
    `CHK(hresp_o, 1'b0)
    v = d[7:0];
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // short run of the counter from a start value, stopped again afterwards
  task automatic burst(input logic [7:0] start, input logic [7:0] ctl, input int n);
    wr(`T8_OFS_COUNT, start);
    wr(`T8_OFS_CONTROL, ctl);
    run(n);
    wr(`T8_OFS_CONTROL, ctl & 8'hF8);
    rd(`T8_OFS_COUNT, c);
  endtask
  task automatic ack(input logic cmp, input logic ovf);
    @(posedge sys_clk_i);
    compare_irq_ack_i <= cmp;
    overflow_irq_ack_i <= ovf;
    @(posedge sys_clk_i);
    compare_irq_ack_i <= 1'b0;
    overflow_irq_ack_i <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs about 15000 cycles
  initial
  begin
    run(60000);
    bad_count++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    {hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i, go, pulses} = '0;
    {compare_irq_ack_i, overflow_irq_ack_i} = 2'b00;
    run(20);
    rst_i <= 1'b0;
    rd_chk(`T8_OFS_CONTROL, 8'h00);
    rd_chk(`T8_OFS_COUNT, 8'h00);
    rd_chk(`T8_OFS_COMPARE, 8'h00);
    rd_chk(`T8_OFS_IRQ_MASK, 8'h00);
    `CHK(pin_override_o, 1'b0)
    wr(32'h1C, 8'hFF);
    rd_chk(32'h1C, 8'h00);
    wr(`T8_OFS_IRQ_MASK, 8'h03);
    rd_chk(`T8_OFS_IRQ_MASK, 8'h03);
    wr(`T8_OFS_COMPARE, 8'hA5);
    rd_chk(`T8_OFS_COMPARE, 8'hA5);
    wr(`T8_OFS_COUNT, 8'h5A);
    run(10);
    rd_chk(`T8_OFS_COUNT, 8'h5A);
    // forced compares with the timer stopped
    wr(`T8_OFS_AUX, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      wr(`T8_OFS_CONTROL, frc_ctl[i]);
      run(2);
      `CHK(waveform_output_o, frc_exp[i])
    end
    rd_chk(`T8_OFS_CONTROL, 8'h10);
    rd_chk(`T8_OFS_FLAGS, 8'h00);
    `CHK({waveform_output_oe_o, pin_override_o, pad}, 3'b110)
    wr(`T8_OFS_AUX, 8'h00);
    run(2);
    `CHK({waveform_output_oe_o, pin_override_o}, 2'b01)
    wr(`T8_OFS_COUNT, 8'h33);
    wr(`T8_OFS_CONTROL, 8'hD0);
    rd_chk(`T8_OFS_COUNT, 8'h33);
    // clear-on-match keeps the count at or below the compare value
    wr(`T8_OFS_COMPARE, 8'h05);
    burst(8'h00, 8'h41, 40);
    `CHK(c <= 8'h05, 1'b1)
    wr(`T8_OFS_FLAGS, 8'h03);
    rd_chk(`T8_OFS_FLAGS, 8'h00);
    // overflow and compare flags, requests, masking and acknowledges
    wr(`T8_OFS_COMPARE, 8'hF8);
    wr(`T8_OFS_AUX, 8'h01);
    burst(8'hF0, 8'h01, 30);
    rd_chk(`T8_OFS_FLAGS, 8'h03);
    `CHK({compare_irq_o, overflow_irq_o}, 2'b11)
    ack(1'b1, 1'b0);
    run(2);
    rd_chk(`T8_OFS_FLAGS, 8'h01);
    `CHK(compare_irq_o, 1'b0)
    wr(`T8_OFS_AUX, 8'h00);
    run(2);
    `CHK(overflow_irq_o, 1'b0)
    ack(1'b0, 1'b1);
    rd_chk(`T8_OFS_FLAGS, 8'h00);
    // normal mode toggle: exactly one match at F8 on the way up from F0
    w0 = waveform_output_o;
    burst(8'hF0, 8'h11, 20);
    `CHK(waveform_output_o, ~w0)
    // prescaler taps: about ten counts in ten divided periods
    for (int i = 0; i < 4; i++)
    begin
      burst(8'h00, 8'(i + 2), 10 * div_n[i]);
      `CHK(c >= 8'd9 && c <= 8'd12, 1'b1)
    end
    // external pin, rising then falling edges
    for (int i = 0; i < 2; i++)
    begin
      wr(`T8_OFS_COUNT, 8'h00);
      wr(`T8_OFS_CONTROL, 8'h07 - 8'(i));
      pulses <= 8'(5 - 2 * i);
      go <= 1'b1;
      run(1);
      go <= 1'b0;
      for (int k = 0; k < 200 && busy; k++) run(1);
      run(6);
      wr(`T8_OFS_CONTROL, 8'h00);
      rd_chk(`T8_OFS_COUNT, 8'(5 - 2 * i));
    end
    // phase correct, non-inverting: cleared on the up match, set on the down match
    wr(`T8_OFS_COMPARE, 8'h80);
    burst(8'h70, 8'h29, 40);
    `CHK(c >= 8'h90 && c <= 8'hA8, 1'b1)
    `CHK(waveform_output_o, 1'b0)
    burst(c, 8'h29, 240);
    `CHK(c >= 8'h60 && c <= 8'h80, 1'b1)
    `CHK(waveform_output_o, 1'b1)
    // inverting with compare at TOP: the only action is the clear at TOP
    wr(`T8_OFS_CONTROL, 8'h00);
    wr(`T8_OFS_COMPARE, 8'hFF);
    burst(c, 8'h39, 400);
    `CHK(waveform_output_o, 1'b0)
    // fast PWM, non-inverting, set at bottom and cleared at match
    wr(`T8_OFS_AUX, 8'h02);
    wr(`T8_OFS_COMPARE, 8'h80);
    burst(8'hF0, 8'h69, 100);
    `CHK(c >= 8'h40 && c <= 8'h70, 1'b1)
    `CHK(pad, 1'b1)
    wr(`T8_OFS_CONTROL, 8'hE8);
    run(2);
    `CHK(waveform_output_o, 1'b1)
    burst(c, 8'h69, 80);
    `CHK(c >= 8'h90 && c <= 8'hC0, 1'b1)
    `CHK(waveform_output_o, 1'b0)
    report_and_stop();
  end
endmodule // test_timer8_compare_pwm_regs
